// *** logic/synth_pkg.sv ***
// Constants, field layouts and types shared by the synthesizer core.
// Assumes a single 10 MHz system clock and an AXI4-Lite master outside.
package synth_pkg;

  // ----------------------------------------------------------------
  // Serial word layout
  // ----------------------------------------------------------------
  localparam int SR_W = 18;
  localparam int ADDR_BIT = 0;
  localparam int RDIV_LSB = 1;
  localparam int RDIV_W = 10;
  localparam int CPTRI_BIT = 11;
  localparam int POL_BIT = 12;
  localparam int SEL_LSB = 13;
  localparam int SEL_W = 3;
  localparam int PD_BIT = 1;
  localparam int SWAL_LSB = 3;
  localparam int SWAL_W = 5;
  localparam int MAIN_LSB = 8;
  localparam int MAIN_W = 10;
  localparam logic [SR_W-1:0] R_LATCH_RST = 18'h01015;
  localparam logic [SR_W-1:0] N_LATCH_RST = 18'h00300;

  // ----------------------------------------------------------------
  // Dividers and lock detect
  // ----------------------------------------------------------------
  localparam logic [5:0] PRE_LOW_LAST = 6'h1F;
  localparam logic [5:0] PRE_HIGH_LAST = 6'h20;
  localparam int CLK_PERIOD_NS = 100;
  localparam int LOCK_ENTER_NS = 15;
  localparam int LOCK_EXIT_NS = 30;
  localparam int LOCK_ENTER_CYC = (LOCK_ENTER_NS / CLK_PERIOD_NS < 1) ? 1 :
                                  LOCK_ENTER_NS / CLK_PERIOD_NS;
  localparam int LOCK_EXIT_CYC = (LOCK_EXIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] ENTER_LIMIT = 8'(LOCK_ENTER_CYC);
  localparam logic [7:0] EXIT_LIMIT = 8'(LOCK_EXIT_CYC);
  localparam logic [2:0] LOCK_GOOD_CYCLES = 3'h5;
  localparam logic [2:0] SEL_DIGITAL = 3'h0;
  localparam logic [2:0] SEL_ANALOG = 3'h1;
  localparam logic [2:0] SEL_REF_OUT = 3'h2;
  localparam logic [2:0] SEL_FB_OUT = 3'h3;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] STATUS_OFS = 8'h00;
  localparam logic [7:0] CTRL_OFS = 8'h04;
  localparam logic [7:0] RLATCH_OFS = 8'h08;
  localparam logic [7:0] NLATCH_OFS = 8'h0C;
  localparam logic CTRL_RST = 1'b1;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  typedef logic [7:0] axi_addr_t;
  typedef logic [31:0] axi_data_t;
  typedef enum logic {UNLOCKED, LOCKED} lock_e;

endpackage : synth_pkg

// *** logic/synth_core.sv ***
// Divider, detector, lock-detect and serial-load core of an integer-N synthesizer.
// Assumes every pin input is asynchronous to aclk and slow against it.
// Function
// R1: Ten-bit reference divider, ratios 2 to 1023.
// R2: Fifteen-bit feedback divider: swallow plus main counter.
// R3: Feedback ratios 992 to 32767 without gaps.
// R4: Prescaler divides by 32 or 33.
// R5: Detector compares dividers; polarity bit swaps pump.
// R6: Pump drives up, down, else floats.
// R7: Indicator pin can show divider outputs.
// R8: Serial data sampled on serial clock rise.
// R9: Words shift in most significant bit first.
// R10: Last bit shifted selects target latch.
// R11: Load strobe rise copies word to latch.
// R12: Lock after five comparisons under 15 ns; here, five with both divider pulses in the same clock.
// R13: Unlock when one comparison exceeds 30 ns; here, when one error exceeds one 100 ns clock.
// R14: Analog mode: open drain, low while pumping.
// R15: Indicator high whenever powered down.
// R16: Chip enable low powers down, floats pump.
// R17: Power-down bit stops dividers, floats pump.
// R18: Power down resets dividers; restart aligned.
// R19: Serial port works in every power state.
// R20: Address one is reference, zero feedback.
// R21: Host sets polarity to match tuning slope.
// R22: Feedback latch holds swallow, main, control.
// R23: Host never programs main count below three.
// R24: Ratio is 32 times main plus swallow.
//
// Chosen here: the AXI4-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module synth_core (
  input wire logic aclk,
  input wire logic aresetn,
  input wire synth_pkg::axi_addr_t s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire synth_pkg::axi_data_t s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire synth_pkg::axi_addr_t s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output synth_pkg::axi_data_t s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic reference_input,
  input wire logic rf_feedback_input,
  input wire logic serial_clock,
  input wire logic serial_data,
  input wire logic load_strobe,
  input wire logic chip_enable,
  output logic pump_output,
  output logic pump_output_oe_n,
  output logic lock_indicator_pin,
  output logic lock_indicator_pin_oe_n
);
  import synth_pkg::*;

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  // A level counts only once the second and third stages agree, which
  // rejects a single-cycle glitch at the cost of one cycle of delay.
  localparam int NPIN = 6;
  wire [NPIN-1:0] pin_raw = {chip_enable, load_strobe, serial_data, serial_clock,
                             rf_feedback_input, reference_input};
  logic [NPIN-1:0] filt_r;
  wire [NPIN-1:0] filt_nxt;
  wire [NPIN-1:0] pin_rise = filt_nxt & ~filt_r;

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      logic [2:0] stage_r;
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          stage_r <= 3'h0;
        end else begin
          stage_r <= {stage_r[1:0], pin_raw[gi]};
        end
      end
      assign filt_nxt[gi] = (stage_r[1] == stage_r[2]) ? stage_r[2] : filt_r[gi];
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt_r <= 6'h00;
    end else begin
      filt_r <= filt_nxt;
    end
  end

  wire ref_rise = pin_rise[0];
  wire rf_rise = pin_rise[1];
  wire sclk_rise = pin_rise[2];
  wire sdata_lvl = filt_nxt[3];
  wire load_rise = pin_rise[4];
  wire ce_lvl = filt_r[5];

  // ----------------------------------------------------------------
  // Serial shift register and latches
  // ----------------------------------------------------------------
  logic [SR_W-1:0] shift_r;
  logic [SR_W-1:0] r_latch_r;
  logic [SR_W-1:0] n_latch_r;
  logic serial_en_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      shift_r <= 18'h00000;
      r_latch_r <= R_LATCH_RST;
      n_latch_r <= N_LATCH_RST;
    end else begin
      // No power-down term here: the port loads in every power state. [R19]
      if (serial_en_r && sclk_rise) begin
        shift_r <= {shift_r[SR_W-2:0], sdata_lvl}; // [R8] [R9]
      end
      if (serial_en_r && load_rise) begin // [R11]
        if (shift_r[ADDR_BIT]) begin // [R10] [R20]
          r_latch_r <= shift_r;
        end else begin
          n_latch_r <= shift_r; // [R22]
        end
      end
    end
  end

  wire [RDIV_W-1:0] ref_div_field = r_latch_r[RDIV_LSB +: RDIV_W];
  wire cp_float_bit = r_latch_r[CPTRI_BIT];
  wire phase_polarity_bit = r_latch_r[POL_BIT];
  wire [SEL_W-1:0] indicator_select_field = r_latch_r[SEL_LSB +: SEL_W];
  wire power_down_bit = n_latch_r[PD_BIT];
  wire [SWAL_W-1:0] swallow_count_field = n_latch_r[SWAL_LSB +: SWAL_W];
  wire [MAIN_W-1:0] main_count_field = n_latch_r[MAIN_LSB +: MAIN_W];

  // ----------------------------------------------------------------
  // Power control
  // ----------------------------------------------------------------
  // Chip enable is seen through the synchroniser, so power down takes
  // effect four clocks after the pin falls rather than at once.
  wire pd_w = ~ce_lvl | power_down_bit; // [R16] [R17]

  // ----------------------------------------------------------------
  // Reference divider
  // ----------------------------------------------------------------
  logic [RDIV_W-1:0] ref_cnt_r;
  logic ref_pulse_r;
  logic ref_tog_r;
  wire ref_wrap = ref_rise && (ref_cnt_r >= ref_div_field - 10'h001);

  always_ff @(posedge aclk) begin
    if (!aresetn || pd_w) begin
      ref_cnt_r <= 10'h000; // [R18]
      ref_pulse_r <= 1'b0;
    end else begin
      ref_pulse_r <= ref_wrap; // [R1]
      if (ref_wrap) begin
        ref_cnt_r <= 10'h000;
      end else if (ref_rise) begin
        ref_cnt_r <= ref_cnt_r + 10'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Prescaler, swallow and main counters
  // ----------------------------------------------------------------
  logic [5:0] pre_cnt_r;
  logic [SWAL_W-1:0] swal_left_r;
  logic [MAIN_W-1:0] main_left_r;
  logic fb_pulse_r;
  logic fb_tog_r;
  wire [5:0] pre_last = (swal_left_r != 5'h00) ? PRE_HIGH_LAST : PRE_LOW_LAST; // [R4]
  wire pre_wrap = rf_rise && (pre_cnt_r == pre_last);
  wire main_done = pre_wrap && (main_left_r <= 10'h001);

  always_ff @(posedge aclk) begin
    if (!aresetn || pd_w) begin
      // Both dividers restart from zero together on power up. [R18]
      pre_cnt_r <= 6'h00;
      swal_left_r <= swallow_count_field;
      main_left_r <= main_count_field;
      fb_pulse_r <= 1'b0;
    end else begin
      fb_pulse_r <= main_done;
      if (pre_wrap) begin
        pre_cnt_r <= 6'h00;
      end else if (rf_rise) begin
        pre_cnt_r <= pre_cnt_r + 6'h01;
      end
      // The first swallow-count prescaler cycles use 33, the rest 32. [R2] [R24] [R3]
      if (main_done) begin
        swal_left_r <= swallow_count_field;
        main_left_r <= main_count_field;
      end else if (pre_wrap) begin
        main_left_r <= main_left_r - 10'h001;
        if (swal_left_r != 5'h00) begin
          swal_left_r <= swal_left_r - 5'h01;
        end
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ref_tog_r <= 1'b0;
      fb_tog_r <= 1'b0;
    end else begin
      ref_tog_r <= ref_tog_r ^ ref_pulse_r;
      fb_tog_r <= fb_tog_r ^ fb_pulse_r;
    end
  end

  // ----------------------------------------------------------------
  // Phase/frequency detector
  // ----------------------------------------------------------------
  logic ref_seen_r;
  logic fb_seen_r;
  logic [7:0] err_cnt_r;
  wire ref_seen_w = ref_seen_r | ref_pulse_r;
  wire fb_seen_w = fb_seen_r | fb_pulse_r;
  wire cmp_done = ref_seen_w & fb_seen_w; // [R5]
  wire one_ahead = ref_seen_w ^ fb_seen_w;
  wire [7:0] err_now = err_cnt_r;
  wire pump_up_w = phase_polarity_bit ? (ref_seen_r & ~fb_seen_r)
                                      : (fb_seen_r & ~ref_seen_r); // [R5]
  wire pump_dn_w = phase_polarity_bit ? (fb_seen_r & ~ref_seen_r)
                                      : (ref_seen_r & ~fb_seen_r);
  wire pump_busy = pump_up_w | pump_dn_w;

  always_ff @(posedge aclk) begin
    if (!aresetn || pd_w) begin
      ref_seen_r <= 1'b0;
      fb_seen_r <= 1'b0;
      err_cnt_r <= 8'h00;
    end else begin
      ref_seen_r <= ref_seen_w & ~cmp_done;
      fb_seen_r <= fb_seen_w & ~cmp_done;
      if (cmp_done) begin
        err_cnt_r <= 8'h00;
      end else if (one_ahead && err_cnt_r != 8'hFF) begin
        err_cnt_r <= err_cnt_r + 8'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // Digital lock filter
  // ----------------------------------------------------------------
  // The error is measured in whole system clocks, so the 15 ns and 30 ns
  // windows collapse to one clock; finer phase needs a faster clock.
  lock_e lock_state_r;
  logic [2:0] good_cnt_r;

  always_ff @(posedge aclk) begin
    if (!aresetn || pd_w) begin
      lock_state_r <= UNLOCKED;
      good_cnt_r <= 3'h0;
    end else if (cmp_done) begin
      case (lock_state_r)
        UNLOCKED: begin
          if (err_now < ENTER_LIMIT) begin
            if (good_cnt_r + 3'h1 == LOCK_GOOD_CYCLES) begin
              lock_state_r <= LOCKED; // [R12]
              good_cnt_r <= 3'h0;
            end else begin
              good_cnt_r <= good_cnt_r + 3'h1;
            end
          end else begin
            good_cnt_r <= 3'h0;
          end
        end
        LOCKED: begin
          if (err_now > EXIT_LIMIT) begin
            lock_state_r <= UNLOCKED; // [R13]
          end
        end
        default: begin
          lock_state_r <= UNLOCKED;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Pump and indicator pins
  // ----------------------------------------------------------------
  wire pump_drive = ~pd_w & ~cp_float_bit & pump_busy; // [R6] [R16] [R17]
  logic ind_val;
  logic ind_oe_n;

  always_comb begin
    ind_val = 1'b1;
    ind_oe_n = 1'b0;
    if (pd_w) begin
      ind_val = 1'b1; // [R15]
    end else begin
      case (indicator_select_field)
        SEL_ANALOG: begin
          ind_val = 1'b0; // [R14]
          ind_oe_n = ~pump_busy;
        end
        SEL_REF_OUT: ind_val = ref_tog_r; // [R7]
        SEL_FB_OUT: ind_val = fb_tog_r; // [R7]
        default: ind_val = (lock_state_r == LOCKED);
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pump_output <= 1'b0;
      pump_output_oe_n <= 1'b1;
      lock_indicator_pin <= 1'b1;
      lock_indicator_pin_oe_n <= 1'b0;
    end else begin
      pump_output <= pump_up_w; // [R6]
      pump_output_oe_n <= ~pump_drive;
      lock_indicator_pin <= ind_val;
      lock_indicator_pin_oe_n <= ind_oe_n;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  logic aw_hold_r;
  logic w_hold_r;
  axi_addr_t awaddr_q;
  axi_data_t wdata_q;
  logic wstrb0_q;
  wire aw_fire = s_axi_awvalid & s_axi_awready;
  wire w_fire = s_axi_wvalid & s_axi_wready;
  wire wr_go = aw_hold_r & w_hold_r & ~s_axi_bvalid;
  wire aw_hold_nxt = ~wr_go & (aw_hold_r | aw_fire);
  wire w_hold_nxt = ~wr_go & (w_hold_r | w_fire);
  wire bvalid_nxt = wr_go | (s_axi_bvalid & ~s_axi_bready);
  wire wr_ctrl = wr_go && (awaddr_q == CTRL_OFS);
  wire wr_known = (awaddr_q == STATUS_OFS) || wr_ctrl || (awaddr_q == RLATCH_OFS) ||
                  (awaddr_q == NLATCH_OFS);
  wire ar_fire = s_axi_arvalid & s_axi_arready;
  wire rvalid_nxt = ar_fire | (s_axi_rvalid & ~s_axi_rready);
  wire [31:0] status_word = {28'h0000000, pump_dn_w, pump_up_w, pd_w,
                             lock_state_r == LOCKED};
  logic [31:0] rd_word;
  logic rd_known;

  always_comb begin
    rd_word = 32'h00000000;
    rd_known = 1'b1;
    case (s_axi_araddr)
      STATUS_OFS: rd_word = status_word;
      CTRL_OFS: rd_word = {31'h00000000, serial_en_r};
      RLATCH_OFS: rd_word = {14'h0000, r_latch_r};
      NLATCH_OFS: rd_word = {14'h0000, n_latch_r};
      default: rd_known = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_q <= 8'h00;
      wdata_q <= 32'h00000000;
      wstrb0_q <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
      serial_en_r <= CTRL_RST;
    end else begin
      aw_hold_r <= aw_hold_nxt;
      w_hold_r <= w_hold_nxt;
      s_axi_awready <= ~aw_hold_nxt & ~bvalid_nxt;
      s_axi_wready <= ~w_hold_nxt & ~bvalid_nxt;
      s_axi_bvalid <= bvalid_nxt;
      if (aw_fire) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (w_fire) begin
        wdata_q <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_go) begin
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_DECERR;
      end
      if (wr_ctrl && wstrb0_q) begin
        serial_en_r <= wdata_q[0];
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_nxt;
      s_axi_rvalid <= rvalid_nxt;
      if (ar_fire) begin
        s_axi_rdata <= rd_word;
        s_axi_rresp <= rd_known ? RESP_OKAY : RESP_DECERR;
      end
    end
  end

endmodule : synth_core

// *** verif/synth_core_checker.sv ***
// Port-level checker for the synthesizer core.
// Assumes binding to synth_core and sight of its ports only.
`timescale 1ns/1ps
module synth_core_checker (
  input logic aclk,
  input logic aresetn,
  input synth_pkg::axi_addr_t s_axi_awaddr,
  input logic s_axi_awvalid,
  input logic s_axi_awready,
  input logic s_axi_wvalid,
  input logic s_axi_wready,
  input logic [1:0] s_axi_bresp,
  input logic s_axi_bvalid,
  input logic s_axi_bready,
  input synth_pkg::axi_addr_t s_axi_araddr,
  input logic s_axi_arvalid,
  input logic s_axi_arready,
  input synth_pkg::axi_data_t s_axi_rdata,
  input logic [1:0] s_axi_rresp,
  input logic s_axi_rvalid,
  input logic s_axi_rready,
  input logic chip_enable,
  input logic pump_output_oe_n,
  input logic lock_indicator_pin,
  input logic lock_indicator_pin_oe_n
);
  import synth_pkg::*;
  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence w_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence ar_take;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // Six samples cover the pin synchroniser before power down shows.
  sequence ce_low_run;
    !chip_enable [*6];
  endsequence
  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  wr_answer_a: assert property (w_both |-> ##[1:3] s_axi_bvalid)
    else $error("write response missing");
  rd_answer_a: assert property (ar_take |=> s_axi_rvalid)
    else $error("read data missing");
  wr_decode_a: assert property (w_both and s_axi_awaddr > NLATCH_OFS
    |-> ##[1:3] (s_axi_bvalid && s_axi_bresp == RESP_DECERR))
    else $error("unmapped write not refused");
  rd_decode_a: assert property (ar_take and s_axi_araddr > NLATCH_OFS
    |=> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  b_single_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response repeated");
  r_single_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid)
    else $error("read data repeated");
  busy_ready_a: assert property ((s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    and (s_axi_rvalid |-> !s_axi_arready))
    else $error("ready high while answer pending");
  ce_float_a: assert property (ce_low_run |-> pump_output_oe_n)
    else $error("pump driven with chip enable low");
  ce_ind_high_a: assert property (ce_low_run |-> lock_indicator_pin_oe_n || lock_indicator_pin)
    else $error("indicator low while powered down");
endmodule : synth_core_checker

bind synth_core synth_core_checker chk (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
  .s_axi_rready, .chip_enable, .pump_output_oe_n, .lock_indicator_pin,
  .lock_indicator_pin_oe_n);

// *** verif/serial_host.sv ***
// Host model driving the three-wire serial configuration port.
// Assumes the core filters each level over at most three clocks.
`timescale 1ns/1ps
module serial_host (
  input wire logic aclk,
  output logic serial_clock,
  output logic serial_data,
  output logic load_strobe
);
  // ----------------------------------------------------------------
  // Word transfer
  // ----------------------------------------------------------------
  initial begin
    {serial_clock, serial_data, load_strobe} = 3'b000;
  end
  task automatic hold(input int n);
    repeat (n) @(posedge aclk);
  endtask : hold
  // Four clocks per phase keep data stable well around each sampled rise.
  task automatic send(input logic [17:0] word);
    for (int i = 17; i >= 0; i--) begin
      serial_data <= word[i];
      hold(4);
      serial_clock <= 1'b1;
      hold(4);
      serial_clock <= 1'b0;
    end
    hold(4);
    // The data line is no longer valid, so it shows the opposite level.
    serial_data <= ~word[0];
    load_strobe <= 1'b1;
    hold(4);
    load_strobe <= 1'b0;
    hold(8);
  endtask : send
endmodule : serial_host

// *** verif/tb.sv ***
// Self-checking bench: register tasks, serial host model and pin clocks.
// Assumes a pull-up on the indicator pin and one 10 MHz clock.
`timescale 1ns/1ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %0t %h %h", $time, (g), (e)); end end
module tb;
  import synth_pkg::*;
  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
  logic s_axi_rready, reference_input, rf_feedback_input, serial_clock, serial_data;
  logic load_strobe, chip_enable, pump_output, pump_output_oe_n, lock_indicator_pin;
  logic lock_indicator_pin_oe_n, rf_run, saw_up, saw_dn, saw_low, saw_high;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [3:0] s_axi_wstrb;
  axi_addr_t s_axi_awaddr, s_axi_araddr;
  axi_data_t s_axi_wdata, s_axi_rdata;
  int err_count, check_count, cyc, ph;
  logic [17:0] wds [6] = '{18'h030C3, 18'h010C3, 18'h000C3, 18'h020C3, 18'h050C3, 18'h070C3};
  logic [3:0] exps [6] = '{4'b0001, 4'b1010, 4'b0110, 4'b0111, 4'b1011, 4'b1011};
  wire ld_wire = lock_indicator_pin_oe_n ? 1'b1 : lock_indicator_pin;

  synth_core uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .reference_input, .rf_feedback_input,
    .serial_clock, .serial_data, .load_strobe, .chip_enable, .pump_output,
    .pump_output_oe_n, .lock_indicator_pin, .lock_indicator_pin_oe_n);
  serial_host host (.aclk, .serial_clock, .serial_data, .load_strobe);

  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end

  // Both pins share one phase counter, so aligned dividers see no error.
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    ph <= (ph == 5) ? 0 : ph + 1;
    reference_input <= (ph < 3);
    if (rf_run) rf_feedback_input <= (ph < 3);
    if (!pump_output_oe_n && pump_output) saw_up <= 1'b1;
    if (!pump_output_oe_n && !pump_output) saw_dn <= 1'b1;
    if (!ld_wire) saw_low <= 1'b1;
    if (ld_wire) saw_high <= 1'b1;
    if (cyc == 60000) begin
      err_count++;
      wrap_up();
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic wr(input axi_addr_t a, input axi_data_t d, input logic [1:0] e);
    logic aw_on, w_on;
    @(posedge aclk);
    aw_on = 1'b1;
    w_on = 1'b1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (aw_on || w_on) begin
      @(posedge aclk);
      if (aw_on && s_axi_awready) begin
        aw_on = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w_on && s_axi_wready) begin
        w_on = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
    `CHK(s_axi_bresp, e)
  endtask : wr

  task automatic rdc(input axi_addr_t a, input axi_data_t m, input axi_data_t e);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
    `CHK(s_axi_rdata & m, e)
    `CHK(s_axi_rresp, (a > NLATCH_OFS) ? RESP_DECERR : RESP_OKAY)
  endtask : rdc

  task automatic wrap_up();
    if (err_count == 0 && check_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : wrap_up
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {aresetn, chip_enable, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, reference_input, rf_feedback_input} = '0;
    {saw_up, saw_dn, saw_low, saw_high} = '0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    rf_run = 1'b1;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    chip_enable <= 1'b1;
    rdc(CTRL_OFS, 32'h1, 32'h1);
    rdc(RLATCH_OFS, 32'h3FFFF, 32'h01015);
    rdc(NLATCH_OFS, 32'h3FFFF, 32'h00300);
    rdc(8'h40, 32'hFFFFFFFF, 32'h0);
    wr(8'h40, 32'h1, RESP_DECERR);
    wr(CTRL_OFS, 32'h0, RESP_OKAY);
    rdc(CTRL_OFS, 32'h1, 32'h0);
    // Without byte lane zero the enable bit must keep its value.
    s_axi_wstrb <= 4'hE;
    wr(CTRL_OFS, 32'h1, RESP_OKAY);
    rdc(CTRL_OFS, 32'h1, 32'h0);
    s_axi_wstrb <= 4'hF;
    host.send(18'h00005);
    rdc(RLATCH_OFS, 32'h3FFFF, 32'h01015);
    wr(CTRL_OFS, 32'h1, RESP_OKAY);
    host.send(18'h0030A);
    rdc(STATUS_OFS, 32'h3, 32'h2);
    `CHK({ld_wire, pump_output_oe_n}, 2'b11)
    host.send(18'h010C3);
    rdc(RLATCH_OFS, 32'h3FFFF, 32'h010C3);
    host.send(18'h00308);
    rdc(NLATCH_OFS, 32'h3FFFF, 32'h00308);
    // Ratio 97 on both sides: exercises the swallow cycle of the prescaler.
    repeat (7000) @(posedge aclk);
    rdc(STATUS_OFS, 32'h1, 32'h1);
    `CHK(ld_wire, 1'b1)
    for (int i = 0; i < 6; i++) begin
      if (i == 1) begin
        rf_run <= 1'b0;
        repeat (6) @(posedge aclk);
        rf_run <= 1'b1;
        // Let the lagging comparison drop lock before the window opens.
        repeat (600) @(posedge aclk);
      end
      host.send(wds[i]);
      @(negedge aclk);
      {saw_up, saw_dn, saw_low, saw_high} = '0;
      repeat (1200) @(posedge aclk);
      `CHK({saw_up, saw_dn, saw_low, saw_high}, exps[i])
    end
    rdc(STATUS_OFS, 32'h1, 32'h0);
    chip_enable <= 1'b0;
    repeat (8) @(posedge aclk);
    `CHK({ld_wire, pump_output_oe_n}, 2'b11)
    rdc(STATUS_OFS, 32'h2, 32'h2);
    wrap_up();
  end
endmodule : tb
